// >>> include/ied_regs.svh
// Constants of the interrupt and exception dispatch block.
// Overview of operation
// - Pin takes any vector; local controller 16 up
// - Local controller flags illegal low vectors
// - One enable flag masks all maskable interrupts
// - Software interrupt calls handler for any vector
// - Software vector 2 skips nonmaskable hardware state
// - Software interrupts ignore the enable flag
// - Software interrupts never push error codes
// - Overflow, breakpoint, range instructions raise exceptions
// - Machine check uses vector 18 with code
// - Fault returns to the faulting instruction
// - Trap returns to the next instruction
// - Trap in a branch returns to target
// - Abort location may be imprecise
// - Exceptions and interrupts only at boundaries
// - Interrupt returns to next due instruction
// - Repeat instruction interrupted between iterations
// - Recognised only at in-order retirement
// - Prefetch and early decode never signal
// - Reset, flush, clock, management pins bypass dispatch
// - Maskable pin vector fetched from the bus
// - Nonmaskable blocked until interrupt return
`ifndef IED_REGS_SVH
`define IED_REGS_SVH
`define IED_VEC_NMI       8'h02
`define IED_VEC_BP        8'h03
`define IED_VEC_OF        8'h04
`define IED_VEC_BR        8'h05
`define IED_VEC_MC        8'h12
`define IED_VEC_LOCAL_MIN 8'h10
`define IED_RST_FLAG      1'b0
`define IED_RST_VEC       8'h00
`define IED_RST_IP        32'h0000_0000
`endif

// >>> include/ied_pkg.sv
// Types of the interrupt and exception dispatch block.
package ied_pkg;
  typedef enum logic [1:0] {
    IED_CLS_FAULT = 2'h0,
    IED_CLS_TRAP  = 2'h1,
    IED_CLS_ABORT = 2'h2,
    IED_CLS_MASKABLE_INT_PIN  = 2'h3
  } ied_class_t;
  typedef enum logic [1:0] {
    IED_SWI_INTN  = 2'h0,
    IED_SWI_INT3  = 2'h1,
    IED_SWI_INTO  = 2'h2,
    IED_SWI_BOUND = 2'h3
  } ied_swi_t;
  typedef enum logic [1:0] {
    IED_ST_IDLE = 2'h0,
    IED_ST_NMI  = 2'h1
  } ied_state_t;
endpackage : ied_pkg

// >>> design/ied_dispatch.sv
// Interrupt and exception dispatch at the retirement boundary.
`timescale 1ns/1ps
`default_nettype none
`include "ied_regs.svh"
module ied_dispatch (
  input  wire logic              clk_i,
  input  wire logic              reset_n_i,
  input  wire logic              retire_boundary_i,
  input  wire logic              rep_iter_done_i,
  input  wire logic [31:0]       fault_ip_i,
  input  wire logic [31:0]       next_ip_i,
  input  wire logic [31:0]       branch_target_i,
  input  wire logic              branch_taken_i,
  input  wire logic              if_flag_i,
  input  wire logic              maskable_int_pin_i,
  input  wire logic [7:0]        bus_vector_i,
  input  wire logic              bus_vector_valid_i,
  input  wire logic              local_maskable_int_pin_ctrl_req_i,
  input  wire logic [7:0]        local_maskable_int_pin_ctrl_vec_i,
  input  wire logic              nmi_req_i,
  input  wire logic              int_return_instr_i,
  input  wire logic              swi_req_i,
  input  wire ied_pkg::ied_swi_t swi_kind_i,
  input  wire logic [7:0]        swi_vector_i,
  input  wire logic              swi_cond_i,
  input  wire logic              exc_req_i,
  input  wire logic [7:0]        exc_vector_i,
  input  wire ied_pkg::ied_class_t exc_class_i,
  input  wire logic              exc_has_code_i,
  input  wire logic              machine_check_exc_i,
  output logic                   dispatch_valid_o,
  output logic [7:0]             dispatch_vector_o,
  output ied_pkg::ied_class_t    dispatch_class_o,
  output logic [31:0]            dispatch_ret_ip_o,
  output logic                   dispatch_code_valid_o,
  output logic                   dispatch_precise_o,
  output logic                   nmi_blocked_o,
  output logic                   illegal_vector_o,
  output logic                   int_ack_o
);
  import ied_pkg::*;

  // ***************************************************************
  // State and next values
  // ***************************************************************
  ied_state_t  st_r;
  ied_state_t  st_nxt;
  logic        blk_r;
  logic        blk_nxt;
  logic        val_r;
  logic        val_nxt;
  logic [7:0]  vec_r;
  logic [7:0]  vec_nxt;
  ied_class_t  cls_r;
  ied_class_t  cls_nxt;
  logic [31:0] ip_r;
  logic [31:0] ip_nxt;
  logic        code_r;
  logic        code_nxt;
  logic        prec_r;
  logic        prec_nxt;
  logic        ack_r;
  logic        ack_nxt;
  logic        ill_r;
  logic        ill_nxt;

  // ***************************************************************
  // Source qualifiers
  // ***************************************************************
  logic        swi_fires;
  logic        nmi_ready;
  logic        pin_ready;
  logic        lic_ready;
  logic        take_mc;
  logic        take_exc;
  logic        take_swi;
  logic        take_nmi;
  logic        take_pin;
  logic        take_lic;

  // ***************************************************************
  // Helper functions
  // ***************************************************************

  // Both the dispatch path and the illegal-vector flag use this floor.
  function automatic logic local_vec_ok(input logic [7:0] vec);
    local_vec_ok = (vec >= `IED_VEC_LOCAL_MIN);
  endfunction : local_vec_ok

  // Trap return address follows a taken branch.
  function automatic logic [31:0] trap_ip(input logic tk, input logic [31:0] tgt, input logic [31:0] nx);
    trap_ip = tk ? tgt : nx;
  endfunction : trap_ip

  // A repeat instruction cut between iterations restarts at its own address.
  // Its registers already point at the next iteration, so no work is repeated.
  function automatic logic [31:0] maskable_int_pin_ip(input logic rep, input logic [31:0] cur, input logic [31:0] nx);
    maskable_int_pin_ip = rep ? cur : nx;
  endfunction : maskable_int_pin_ip

  // Vector named by each kind of software interrupt.
  function automatic logic [7:0] swi_vec(input ied_swi_t kind, input logic [7:0] operand);
    case (kind)
      IED_SWI_INT3:  swi_vec = `IED_VEC_BP;
      IED_SWI_INTO:  swi_vec = `IED_VEC_OF;
      IED_SWI_BOUND: swi_vec = `IED_VEC_BR;
      default:       swi_vec = operand;
    endcase
  endfunction : swi_vec

  // ***************************************************************
  // Source selection
  // ***************************************************************

  // no mask; the condition gates every kind except INTN: breakpoint, overflow and range checks.
  assign swi_fires = swi_req_i && ((swi_kind_i == IED_SWI_INTN) || swi_cond_i);

  assign nmi_ready = nmi_req_i && (st_r == IED_ST_IDLE);

  assign pin_ready = if_flag_i && maskable_int_pin_i && bus_vector_valid_i;

  assign lic_ready = if_flag_i && local_maskable_int_pin_ctrl_req_i && local_vec_ok(local_maskable_int_pin_ctrl_vec_i);

  // Fixed source order; full priority arbitration lives elsewhere.
  // A refused source is dropped silently, so its requester must hold it.
  // boundary only; retirement; in-order
  always_comb begin
    take_mc  = 1'b0;
    take_exc = 1'b0;
    take_swi = 1'b0;
    take_nmi = 1'b0;
    take_pin = 1'b0;
    take_lic = 1'b0;
    if (retire_boundary_i) begin
      if (machine_check_exc_i) begin
        take_mc = 1'b1;
      end else if (exc_req_i) begin
        take_exc = 1'b1;
      end else if (swi_fires) begin
        take_swi = 1'b1;
      end else if (nmi_ready) begin
        take_nmi = 1'b1;
      end else if (pin_ready) begin
        take_pin = 1'b1;
      end else if (lic_ready) begin
        take_lic = 1'b1;
      end
    end
  end

  // ***************************************************************
  // Nonmaskable blocking state
  // ***************************************************************
  always_comb begin
    st_nxt = st_r;
    if (int_return_instr_i && retire_boundary_i) begin
      st_nxt = IED_ST_IDLE;
    end
    // A fresh entry wins over a release in the same cycle.
    // software leaves state
    if (take_nmi) begin
      st_nxt = IED_ST_NMI;
    end
    blk_nxt = (st_nxt == IED_ST_NMI);
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      st_r  <= IED_ST_IDLE;
      blk_r <= `IED_RST_FLAG;
    end else begin
      st_r  <= st_nxt;
      blk_r <= blk_nxt;
    end
  end

  // ***************************************************************
  // Dispatch record
  // ***************************************************************
  always_comb begin
    val_nxt  = 1'b0;
    vec_nxt  = vec_r;
    cls_nxt  = cls_r;
    ip_nxt   = ip_r;
    code_nxt = 1'b0;
    prec_nxt = prec_r;
    ack_nxt  = 1'b0;
    if (take_mc) begin
      val_nxt  = 1'b1;
      vec_nxt  = `IED_VEC_MC;
      cls_nxt  = IED_CLS_ABORT;
      ip_nxt   = fault_ip_i;
      code_nxt = 1'b1;
      prec_nxt = 1'b0;
    end else if (take_exc) begin
      val_nxt  = 1'b1;
      vec_nxt  = exc_vector_i;
      cls_nxt  = exc_class_i;
      code_nxt = exc_has_code_i;
      prec_nxt = (exc_class_i != IED_CLS_ABORT);
      if (exc_class_i == IED_CLS_TRAP) begin
        ip_nxt = trap_ip(branch_taken_i, branch_target_i, next_ip_i);
      end else begin
        ip_nxt = fault_ip_i;
      end
    end else if (take_swi) begin
      val_nxt  = 1'b1;
      vec_nxt  = swi_vec(swi_kind_i, swi_vector_i);
      prec_nxt = 1'b1;
      // A range check restarts the instruction; the others resume after it.
      if (swi_kind_i == IED_SWI_BOUND) begin
        cls_nxt = IED_CLS_FAULT;
        ip_nxt  = fault_ip_i;
      end else begin
        cls_nxt = IED_CLS_TRAP;
        ip_nxt  = next_ip_i;
      end
    end else if (take_nmi) begin
      val_nxt  = 1'b1;
      vec_nxt  = `IED_VEC_NMI;
      cls_nxt  = IED_CLS_MASKABLE_INT_PIN;
      ip_nxt   = maskable_int_pin_ip(rep_iter_done_i, fault_ip_i, next_ip_i);
      prec_nxt = 1'b1;
    end else if (take_pin) begin
      // any pin vector; vector from bus
      val_nxt  = 1'b1;
      vec_nxt  = bus_vector_i;
      cls_nxt  = IED_CLS_MASKABLE_INT_PIN;
      ip_nxt   = maskable_int_pin_ip(rep_iter_done_i, fault_ip_i, next_ip_i);
      prec_nxt = 1'b1;
      ack_nxt  = 1'b1;
    end else if (take_lic) begin
      val_nxt  = 1'b1;
      vec_nxt  = local_maskable_int_pin_ctrl_vec_i;
      cls_nxt  = IED_CLS_MASKABLE_INT_PIN;
      ip_nxt   = maskable_int_pin_ip(rep_iter_done_i, fault_ip_i, next_ip_i);
      prec_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      val_r  <= `IED_RST_FLAG;
      vec_r  <= `IED_RST_VEC;
      cls_r  <= IED_CLS_FAULT;
      ip_r   <= `IED_RST_IP;
      code_r <= `IED_RST_FLAG;
      prec_r <= `IED_RST_FLAG;
      ack_r  <= `IED_RST_FLAG;
    end else begin
      val_r  <= val_nxt;
      vec_r  <= vec_nxt;
      cls_r  <= cls_nxt;
      ip_r   <= ip_nxt;
      code_r <= code_nxt;
      prec_r <= prec_nxt;
      ack_r  <= ack_nxt;
    end
  end

  // ***************************************************************
  // Illegal local vector flag
  // ***************************************************************

  // The flag repeats each cycle a low vector is offered.
  // The local controller must drop such a request itself; nothing here clears it.
  always_comb begin
    ill_nxt = local_maskable_int_pin_ctrl_req_i && !local_vec_ok(local_maskable_int_pin_ctrl_vec_i);
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      ill_r <= `IED_RST_FLAG;
    end else begin
      ill_r <= ill_nxt;
    end
  end

  // ***************************************************************
  // Outputs
  // ***************************************************************

  // special pins bypass
  // Flush, clock-stop and management pins have no input here at all; reset_n_i only clears the block's registers.
  assign dispatch_valid_o      = val_r;
  assign dispatch_vector_o     = vec_r;
  assign dispatch_class_o      = cls_r;
  assign dispatch_ret_ip_o     = ip_r;
  assign dispatch_code_valid_o = code_r;
  assign dispatch_precise_o    = prec_r;
  assign nmi_blocked_o         = blk_r;
  assign illegal_vector_o      = ill_r;
  assign int_ack_o             = ack_r;

endmodule : ied_dispatch
`default_nettype wire

// >>> test/ied_props.sv
// Port assertions for the dispatch block.
`timescale 1ns/1ps
`default_nettype none
module ied_props (
  input wire logic       clk_i,
  input wire logic       reset_n_i,
  input wire logic       retire_boundary_i,
  input wire logic       if_flag_i,
  input wire logic       nmi_req_i,
  input wire logic       int_return_instr_i,
  input wire logic       swi_req_i,
  input wire ied_pkg::ied_swi_t swi_kind_i,
  input wire logic       swi_cond_i,
  input wire logic       exc_req_i,
  input wire logic       machine_check_exc_i,
  input wire logic       local_maskable_int_pin_ctrl_req_i,
  input wire logic [7:0] local_maskable_int_pin_ctrl_vec_i,
  input wire logic       dispatch_valid_o,
  input wire logic [7:0] dispatch_vector_o,
  input wire logic       dispatch_code_valid_o,
  input wire logic       nmi_blocked_o,
  input wire logic       illegal_vector_o
);
  wire bnd = retire_boundary_i;
  wire hi = exc_req_i || machine_check_exc_i;
  wire sw = bnd && swi_req_i && !hi && (swi_kind_i == ied_pkg::IED_SWI_INTN || swi_cond_i);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  bound_only_a: assert property (!bnd |=> !dispatch_valid_o)
    else $error("dispatch off boundary");
  swi_unmasked_a: assert property (sw |=> dispatch_valid_o)
    else $error("software lost");
  swi_no_code_a: assert property (sw |=> !dispatch_code_valid_o)
    else $error("software code");
  if_mask_a: assert property (bnd && !if_flag_i && !hi && !swi_req_i && !nmi_req_i |=> !dispatch_valid_o)
    else $error("masked taken");
  low_vec_a: assert property ($rose(local_maskable_int_pin_ctrl_req_i) && local_maskable_int_pin_ctrl_vec_i < 8'h10 |=> illegal_vector_o)
    else $error("illegal unflagged");
  mc_vec_a: assert property (bnd && machine_check_exc_i |=> dispatch_vector_o == 8'h12 && dispatch_code_valid_o)
    else $error("machine check");
  nmi_set_a: assert property (bnd && nmi_req_i && !hi && !swi_req_i && !nmi_blocked_o |=> nmi_blocked_o)
    else $error("block not set");
  nmi_hold_a: assert property (nmi_blocked_o && !(bnd && int_return_instr_i) |=> nmi_blocked_o)
    else $error("block dropped");
endmodule : ied_props
bind ied_dispatch ied_props ied_props_inst (.*);
`default_nettype wire

// >>> test/ied_partner.sv
// Model of the interrupt controllers beyond the dispatch block.
`timescale 1ns/1ps
`default_nettype none
module ied_partner (
  input  wire logic       clk_i,
  input  wire logic       int_ack_i,
  output var  logic       pin_o,
  output var  logic [7:0] bus_vec_o,
  output var  logic       bus_vld_o,
  output var  logic       lic_req_o,
  output var  logic [7:0] lic_vec_o
);
  initial begin
    pin_o = 1'b0;
    bus_vec_o = 8'hA5;
    bus_vld_o = 1'b0;
    lic_req_o = 1'b0;
    lic_vec_o = 8'h5A;
  end
  task automatic raise_pin(input logic [7:0] v);
    pin_o = 1'b1;
    bus_vec_o = v;
    bus_vld_o = 1'b1;
  endtask : raise_pin
  // Released bus shows the inverse, so a stale vector cannot pass.
  always begin
    @(posedge clk_i);
    #1;
    if (int_ack_i) begin
      pin_o = 1'b0;
      bus_vld_o = 1'b0;
      bus_vec_o = ~bus_vec_o;
    end
  end
  task automatic lic(input logic [7:0] v);
    lic_req_o = 1'b1;
    lic_vec_o = v;
  endtask : lic
endmodule : ied_partner
`default_nettype wire

// >>> test/testbench.sv
// Self-checking bench for the dispatch block.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import ied_pkg::*;
  logic clk_i = 1'b0, reset_n_i = 1'b0, retire_boundary_i = 1'b0, rep_iter_done_i = 1'b0, if_flag_i = 1'b0;
  logic branch_taken_i = 1'b0, nmi_req_i = 1'b0, int_return_instr_i = 1'b0, swi_req_i = 1'b0, swi_cond_i = 1'b1;
  logic exc_req_i = 1'b0, exc_has_code_i = 1'b1, machine_check_exc_i = 1'b0, pin, bvld, lreq;
  logic [31:0] fault_ip_i = 32'h100, next_ip_i = 32'h104, branch_target_i = 32'h200, dispatch_ret_ip_o;
  logic [7:0] swi_vector_i = 8'h02, exc_vector_i = 8'h0E, bvec, lvec, dispatch_vector_o;
  ied_swi_t swi_kind_i = IED_SWI_INTN;
  ied_class_t exc_class_i = IED_CLS_FAULT, dispatch_class_o;
  logic dispatch_valid_o, dispatch_code_valid_o, dispatch_precise_o, nmi_blocked_o, illegal_vector_o, int_ack_o;
  int error_cnt = 0, tests_run = 0;
  always #4 clk_i = ~clk_i;
  ied_dispatch ied_dispatch_inst (.*, .maskable_int_pin_i(pin), .bus_vector_i(bvec), .bus_vector_valid_i(bvld),
    .local_maskable_int_pin_ctrl_req_i(lreq), .local_maskable_int_pin_ctrl_vec_i(lvec));
  ied_partner ied_partner_inst (.clk_i, .int_ack_i(int_ack_o), .pin_o(pin), .bus_vec_o(bvec), .bus_vld_o(bvld),
    .lic_req_o(lreq), .lic_vec_o(lvec));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic dsp(input logic [7:0] v, input ied_class_t c, input logic [31:0] ip, input logic cv);
    chk(dispatch_valid_o, 1'b1);
    chk(dispatch_vector_o, v);
    chk(dispatch_class_o, c);
    chk(dispatch_ret_ip_o, ip);
    chk(dispatch_code_valid_o, cv);
  endtask : dsp
  // One boundary pulse after an idle edge, so the strobe never falls and rises in one time step.
  // The answer to the boundary edge is visible on return.
  task automatic bnd(input logic r);
    @(posedge clk_i);
    #1;
    retire_boundary_i = 1'b1;
    int_return_instr_i = r;
    @(posedge clk_i);
    #1;
    retire_boundary_i = 1'b0;
    int_return_instr_i = 1'b0;
  endtask : bnd
  task automatic t_soft;
    swi_req_i = 1'b1;
    for (int k = 0; k < 4; k++) begin
      swi_kind_i = ied_swi_t'(k);
      bnd(1'b0);
      dsp(8'h02 + k[7:0], k == 3 ? IED_CLS_FAULT : IED_CLS_TRAP, k == 3 ? 32'h100 : 32'h104, 1'b0);
      chk(nmi_blocked_o, 1'b0);
    end
    swi_kind_i = IED_SWI_INTN;
    swi_vector_i = 8'hFF;
    bnd(1'b0);
    dsp(8'hFF, IED_CLS_TRAP, 32'h104, 1'b0);
    swi_req_i = 1'b0;
  endtask : t_soft
  task automatic t_exc;
    exc_req_i = 1'b1;
    branch_taken_i = 1'b1;
    bnd(1'b0);
    dsp(8'h0E, IED_CLS_FAULT, 32'h100, 1'b1);
    chk(dispatch_precise_o, 1'b1);
    exc_class_i = IED_CLS_TRAP;
    exc_has_code_i = 1'b0;
    bnd(1'b0);
    dsp(8'h0E, IED_CLS_TRAP, 32'h200, 1'b0);
    machine_check_exc_i = 1'b1;
    bnd(1'b0);
    dsp(8'h12, IED_CLS_ABORT, 32'h100, 1'b1);
    chk(dispatch_precise_o, 1'b0);
    exc_req_i = 1'b0;
    machine_check_exc_i = 1'b0;
  endtask : t_exc
  task automatic t_pin;
    ied_partner_inst.raise_pin(8'h0E);
    bnd(1'b0);
    chk(dispatch_valid_o, 1'b0);
    if_flag_i = 1'b1;
    @(posedge clk_i);
    #1;
    chk(dispatch_valid_o, 1'b0);
    rep_iter_done_i = 1'b1;
    bnd(1'b0);
    dsp(8'h0E, IED_CLS_MASKABLE_INT_PIN, 32'h100, 1'b0);
    chk(int_ack_o, 1'b1);
    rep_iter_done_i = 1'b0;
    ied_partner_inst.lic(8'h0F);
    bnd(1'b0);
    chk(illegal_vector_o, 1'b1);
    chk(dispatch_valid_o, 1'b0);
    ied_partner_inst.lic(8'h10);
    bnd(1'b0);
    dsp(8'h10, IED_CLS_MASKABLE_INT_PIN, 32'h104, 1'b0);
    chk(int_ack_o, 1'b0);
  endtask : t_pin
  task automatic t_nmi;
    if_flag_i = 1'b0;
    nmi_req_i = 1'b1;
    bnd(1'b0);
    dsp(8'h02, IED_CLS_MASKABLE_INT_PIN, 32'h104, 1'b0);
    bnd(1'b0);
    chk(dispatch_valid_o, 1'b0);
    nmi_req_i = 1'b0;
    bnd(1'b1);
    chk(nmi_blocked_o, 1'b0);
  endtask : t_nmi
  task automatic final_report;
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : final_report
  initial begin
    repeat (4) @(posedge clk_i);
    #1;
    reset_n_i = 1'b1;
    t_soft();
    t_exc();
    t_pin();
    t_nmi();
    final_report();
  end
  initial begin
    #5000;
    error_cnt++;
    final_report();
  end
endmodule : testbench
`default_nettype wire
